//--- core/iex_exec.sv
/*
 * Execution stage for a subset of an 8-bit core: accumulator and file-memory
 * arithmetic, shift and rotate, pointer add, and the three return forms.
 * Holds the 128-byte file memory, accumulator, flags, interrupt enable and
 * program counter. Assumes the decode stage presents one decoded operation
 * with instValid and holds it until instReady, and that the return stack
 * outside presents its top word combinationally and pops on stackPop.
 */
`timescale 1ns/1ps
// Contract
// RULE1: pointer add sign-extends literal, flags unchanged
// RULE2: pointer sum wraps modulo sixteen bits
// RULE3: add immediate to accumulator, update C DC Z
// RULE4: AND immediate into accumulator, only Z
// RULE5: AND accumulator with file, only Z
// RULE6: destination bit selects accumulator or file
// RULE7: add accumulator and file, update C DC Z
// RULE8: add with carry, update C DC Z
// RULE9: arithmetic shift right keeps bit seven
// RULE10: rotate left through carry, one cycle
// RULE11: interrupt return pops, sets enable, two cycles
// RULE12: plain return pops, two cycles, flags kept
// RULE13: literal return loads accumulator, two cycles
// RULE14: carry bit7, digit carry bit3, zero
module iex_exec
	import iex_pkg::*;
#(
	parameter int PC_W = 15
)(
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst_b,
	// Register port
	input  wire logic [7:0]      regAddr,
	input  wire logic [7:0]      regWrData,
	input  wire logic            regWr,
	input  wire logic            regRd,
	output logic      [7:0]      regRdData,
	// Decoded operation
	input  wire logic            instValid,
	input  wire logic [3:0]      instOp,
	input  wire logic [6:0]      instFile,
	input  wire logic            instDest,
	input  wire logic [7:0]      instLit,
	input  wire logic            instPtrSel,
	output logic                 instReady,
	// Return stack
	input  wire logic [PC_W-1:0] stackTop,
	output logic                 stackPop,
	// Core state
	output logic      [PC_W-1:0] progCounter,
	output logic                 globalIntEnable
);

	// ************************************************************
	// Types and helpers
	// ************************************************************
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RET2 = 1'b1
	} iex_state_t;

	// Operations that read file memory and honour the destination bit
	function automatic logic isFileOp(input iex_op_t op);
		return (op == OP_AND_FILE) || (op == OP_ADD_FILE) || (op == OP_ADD_FILE_C) ||
		       (op == OP_ASR) || (op == OP_ROT_LEFT);
	endfunction : isFileOp

	// Any of the three return forms
	function automatic logic isReturn(input iex_op_t op);
		return (op == OP_RET_INT) || (op == OP_RET) || (op == OP_RET_LIT);
	endfunction : isReturn

	// Address falls into file memory
	function automatic logic isFileAddr(input logic [7:0] addr);
		return addr < 8'(FILE_WORDS);
	endfunction : isFileAddr

	iex_state_t  state;
	iex_state_t  next_state;
	iex_op_t     op;
	logic        accept;
	logic        toAcc;
	logic        toFile;
	logic [7:0]  acc;
	logic [2:0]  status;
	logic [7:0]  fileMem [FILE_WORDS];
	logic [15:0] ptr0;
	logic [15:0] ptr1;
	logic [7:0]  fileRd;
	iex_alu_if   aluIf ();

	// ************************************************************
	// Issue and sequencing
	// ************************************************************

	// Returns hold the stage for a second cycle; others finish in one
	// Codes outside the enum decode as no operation
	assign op        = iex_op_t'(instOp);
	assign instReady = (state == ST_IDLE);
	assign accept    = instValid && instReady;
	assign stackPop  = accept && isReturn(op); // RULE12

	// Two-cycle return sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (accept && isReturn(op)) next_state = ST_RET2; // RULE11
			ST_RET2: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Destination choice: bit 0 to accumulator, bit 1 back to file
	assign toFile = accept && isFileOp(op) && instDest; // RULE6
	assign toAcc  = accept && ((isFileOp(op) && !instDest) || (op == OP_ADD_IMM) ||
	                           (op == OP_AND_IMM) || (op == OP_RET_LIT));

	// ************************************************************
	// Datapath
	// ************************************************************
	// The file is read without a clock so operands arrive in the issue cycle
	assign fileRd        = fileMem[instFile];
	assign aluIf.op      = op;
	assign aluIf.acc     = acc;
	assign aluIf.fileVal = fileRd;
	assign aluIf.lit     = instLit;
	assign aluIf.cIn     = status[BIT_CARRY];

	iex_alu u_alu (
		.alu (aluIf)
	);

	// One decoded window covers all four pointer bytes
	iex_ptr u_ptr (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.addEn   (accept && (op == OP_PTR_ADD)),
		.addSel  (instPtrSel),
		.addLit  (instLit[5:0]),
		.wrEn    (regWr && (regAddr[7:2] == OFF_PTR0_LO[7:2])),
		.wrIdx   (regAddr[1:0]),
		.wrData  (regWrData),
		.ptr0    (ptr0),
		.ptr1    (ptr1)
	);

	// File memory; an instruction write beats a port write at the same edge
	always_ff @(posedge sys_clk) begin
		if (toFile) begin
			fileMem[instFile] <= aluIf.res; // RULE7
		end else if (regWr && isFileAddr(regAddr)) begin
			fileMem[regAddr[6:0]] <= regWrData;
		end
	end

	// Accumulator
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc <= ACC_RST;
		end else if (toAcc) begin
			acc <= aluIf.res; // RULE3
		end else if (regWr && (regAddr == OFF_ACC)) begin
			acc <= regWrData;
		end
	end

	// Flags commit only on the bits the operation names; returns leave them alone
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			status <= STATUS_RST;
		end else if (accept && (aluIf.wrC || aluIf.wrDc || aluIf.wrZ)) begin
			if (aluIf.wrC)  status[BIT_CARRY]  <= aluIf.cOut;  // RULE14
			if (aluIf.wrDc) status[BIT_DCARRY] <= aluIf.dcOut; // RULE14
			if (aluIf.wrZ)  status[BIT_ZERO]   <= aluIf.zOut;  // RULE14
		end else if (regWr && (regAddr == OFF_STATUS)) begin
			status <= regWrData[2:0];
		end
	end

	// Interrupt enable: the interrupt return sets it and wins over a port clear
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			globalIntEnable <= GIE_RST;
		end else if (accept && (op == OP_RET_INT)) begin
			globalIntEnable <= 1'b1; // RULE11
		end else if (regWr && (regAddr == OFF_INT_CTRL)) begin
			globalIntEnable <= regWrData[BIT_GIE];
		end
	end

	// Program counter loads from the stack top on every return form
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			progCounter <= PC_RST;
		end else if (stackPop) begin
			progCounter <= stackTop; // RULE13
		end
	end

	// ************************************************************
	// Register read-back, one cycle after the read strobe
	// ************************************************************
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
		end else if (regRd) begin
			if (isFileAddr(regAddr)) begin
				regRdData <= fileMem[regAddr[6:0]];
			end else begin
				case (regAddr)
					OFF_ACC:      regRdData <= acc;
					OFF_STATUS:   regRdData <= {5'h00, status};
					OFF_INT_CTRL: regRdData <= {globalIntEnable, 7'h00};
					OFF_PTR0_LO:  regRdData <= ptr0[7:0];
					OFF_PTR0_HI:  regRdData <= ptr0[15:8];
					OFF_PTR1_LO:  regRdData <= ptr1[7:0];
					OFF_PTR1_HI:  regRdData <= ptr1[15:8];
					OFF_PC_LO:    regRdData <= progCounter[7:0];
					OFF_PC_HI:    regRdData <= {1'b0, progCounter[PC_W-1:8]};
					default:      regRdData <= 8'h00; // Unmapped reads as zero
				endcase
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// Stage holds for exactly one extra cycle, then frees
	sequence retHold;
		!instReady ##1 instReady;
	endsequence

	// Flags and results, one cycle after the operation is taken
	ptr_flags_kept_a: assert property (accept && op == OP_PTR_ADD |=> $stable(status)) // RULE1
		else $error("pointer add changed the flags");
	add_imm_sum_a: assert property (accept && op == OP_ADD_IMM |=> // RULE3
		acc == 8'($past(acc) + $past(instLit)) && status[BIT_ZERO] == (acc == 8'h00))
		else $error("immediate add gave wrong sum or zero flag");
	and_imm_only_a: assert property (accept && op == OP_AND_IMM |=> // RULE4
		acc == ($past(acc) & $past(instLit)) && status[1:0] == $past(status[1:0]))
		else $error("immediate AND wrong or touched carry");

	// File operations
	and_file_acc_a: assert property (accept && op == OP_AND_FILE && !instDest |=> // RULE5
		acc == ($past(acc) & $past(fileRd)) && status[1:0] == $past(status[1:0]))
		else $error("file AND into accumulator wrong");
	dest_file_a: assert property (toFile |=> $stable(acc)) // RULE6
		else $error("file destination disturbed the accumulator");
	add_carry_out_a: assert property (accept && op == OP_ADD_FILE_C && !instDest |=> // RULE8
		{status[BIT_CARRY], acc} == 9'({1'b0, $past(acc)} + {1'b0, $past(fileRd)} + 9'($past(status[0]))))
		else $error("add with carry gave wrong sum or carry");
	add_dcarry_a: assert property (accept && op == OP_ADD_FILE |=> // RULE7
		status[BIT_DCARRY] == (5'({1'b0, $past(acc[3:0])}) + 5'({1'b0, $past(fileRd[3:0])}) > 5'h0f))
		else $error("digit carry wrong after file add");
	asr_result_a: assert property (accept && op == OP_ASR && !instDest |=> // RULE9
		acc == {$past(fileRd[7]), $past(fileRd[7:1])} && status[BIT_CARRY] == $past(fileRd[0]))
		else $error("arithmetic shift result or carry wrong");
	rot_one_cycle_a: assert property (accept && op == OP_ROT_LEFT && !instDest |=> // RULE10
		instReady && acc == {$past(fileRd[6:0]), $past(status[0])} && status[2:1] == $past(status[2:1]))
		else $error("rotate wrong or took more than one cycle");

	// Return forms: target, enable and the hold cycle
	reti_enable_a: assert property (accept && op == OP_RET_INT |=> // RULE11
		globalIntEnable && progCounter == $past(stackTop) ##0 retHold)
		else $error("interrupt return missed enable, target or timing");
	ret_flags_a: assert property (accept && isReturn(op) |=> $stable(status) ##0 retHold) // RULE12
		else $error("return changed flags or did not take two cycles");
	retlit_acc_a: assert property (accept && op == OP_RET_LIT |=> acc == $past(instLit)) // RULE13
		else $error("literal return did not load the accumulator");

	// A single pop per return; the counter moves on nothing else
	pop_single_a: assert property (stackPop |=> !stackPop) // RULE12
		else $error("stack popped twice for one return");
	pc_only_pop_a: assert property (!stackPop |=> $stable(progCounter)) // RULE12
		else $error("program counter moved without a pop");
	ret_acc_kept_a: assert property (accept && (op == OP_RET || op == OP_RET_INT) |=> $stable(acc)) // RULE12
		else $error("return changed the accumulator");

	// Other operations never stall
	op_no_stall_a: assert property (accept && !isReturn(op) |=> instReady) // RULE10
		else $error("operation stalled the stage");

	// Immediate add carry; pointer add leaves the accumulator
	add_imm_carry_a: assert property (accept && op == OP_ADD_IMM |=> // RULE14
		{status[BIT_CARRY], acc} == 9'({1'b0, $past(acc)} + {1'b0, $past(instLit)}))
		else $error("immediate add carry wrong");
	ptr_acc_kept_a: assert property (accept && op == OP_PTR_ADD |=> $stable(acc)) // RULE1
		else $error("pointer add changed the accumulator");

endmodule : iex_exec

//--- core/iex_pkg.sv
/*
 * Shared constants for the instruction execution subset: operation codes,
 * register map of the plain register port, flag positions and reset values.
 * Assumes a single core clock and an active-low asynchronous reset.
 */
package iex_pkg;

	// ************************************************************
	// Operations handed over by the decode stage
	// ************************************************************
	typedef enum logic [3:0] {
		OP_NOP         = 4'h0,
		OP_PTR_ADD     = 4'h1, // pointer_add_literal
		OP_ADD_IMM     = 4'h2, // add_immediate_acc
		OP_AND_IMM     = 4'h3, // and_immediate_acc
		OP_AND_FILE    = 4'h4, // and_acc_file
		OP_ADD_FILE    = 4'h5, // add_acc_file
		OP_ADD_FILE_C  = 4'h6, // add_acc_file_carry
		OP_ASR         = 4'h7, // arith_shift_right
		OP_ROT_LEFT    = 4'h8, // rotate_left_carry
		OP_RET_INT     = 4'h9, // return_from_interrupt
		OP_RET         = 4'ha, // plain return
		OP_RET_LIT     = 4'hb  // return_with_literal
	} iex_op_t;

	// ************************************************************
	// Register port map (file memory sits below FILE_WORDS)
	// ************************************************************
	localparam int         FILE_WORDS    = 128;
	localparam logic [7:0] OFF_ACC       = 8'h80;
	localparam logic [7:0] OFF_STATUS    = 8'h81;
	localparam logic [7:0] OFF_INT_CTRL  = 8'h82;
	localparam logic [7:0] OFF_PTR0_LO   = 8'h84;
	localparam logic [7:0] OFF_PTR0_HI   = 8'h85;
	localparam logic [7:0] OFF_PTR1_LO   = 8'h86;
	localparam logic [7:0] OFF_PTR1_HI   = 8'h87;
	localparam logic [7:0] OFF_PC_LO     = 8'h88;
	localparam logic [7:0] OFF_PC_HI     = 8'h89;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int          BIT_CARRY    = 0;
	localparam int          BIT_DCARRY   = 1;
	localparam int          BIT_ZERO     = 2;
	localparam int          BIT_GIE      = 7;
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic [2:0]  STATUS_RST   = 3'h0;
	localparam logic        GIE_RST      = 1'b0;
	localparam logic [15:0] PTR_RST      = 16'h0000;
	localparam logic [14:0] PC_RST       = 15'h0000;
	localparam int          RET_CYCLES   = 2;

endpackage : iex_pkg

//--- core/iex_alu_if.sv
/*
 * Carrier between the execution top and its arithmetic unit.
 * Assumes the arithmetic unit is purely combinational.
 */
`timescale 1ns/1ps
interface iex_alu_if;
	import iex_pkg::*;
	iex_op_t    op;
	logic [7:0] acc;
	logic [7:0] fileVal;
	logic [7:0] lit;
	logic       cIn;
	logic [7:0] res;
	logic       cOut;
	logic       dcOut;
	logic       zOut;
	logic       wrC;
	logic       wrDc;
	logic       wrZ;
	modport master (output op, acc, fileVal, lit, cIn, input res, cOut, dcOut, zOut, wrC, wrDc, wrZ);
	modport unit   (input op, acc, fileVal, lit, cIn, output res, cOut, dcOut, zOut, wrC, wrDc, wrZ);
endinterface : iex_alu_if

//--- core/iex_alu.sv
/*
 * Combinational arithmetic unit: adds, ANDs, shift and rotate with flags.
 * Assumes the caller decides where the result goes and when flags commit.
 */
`timescale 1ns/1ps
module iex_alu
	import iex_pkg::*;
(
	// Operands in, result and flag updates out
	iex_alu_if.unit alu
);

	logic [7:0] addB;
	logic       addCin;
	logic [8:0] sum9;
	logic [4:0] nib5;

	// Second operand and carry-in of the adder
	always_comb begin
		addB   = alu.lit;
		addCin = 1'b0;
		case (alu.op)
			OP_ADD_FILE:   addB = alu.fileVal;
			OP_ADD_FILE_C: begin
				addB   = alu.fileVal;
				addCin = alu.cIn; // RULE8
			end
			default:       addB = alu.lit;
		endcase
	end

	// Full and low-nibble sums; the nibble sum yields the digit carry
	assign sum9 = {1'b0, alu.acc} + {1'b0, addB} + {8'h00, addCin};
	assign nib5 = {1'b0, alu.acc[3:0]} + {1'b0, addB[3:0]} + {4'h0, addCin};

	// Result and which flags it touches
	always_comb begin
		alu.res   = 8'h00;
		alu.cOut  = alu.cIn;
		alu.dcOut = nib5[4];
		alu.wrC   = 1'b0;
		alu.wrDc  = 1'b0;
		alu.wrZ   = 1'b0;
		case (alu.op)
			OP_ADD_IMM, OP_ADD_FILE, OP_ADD_FILE_C: begin
				alu.res  = sum9[7:0];  // RULE3
				alu.cOut = sum9[8];    // RULE14
				alu.wrC  = 1'b1;
				alu.wrDc = 1'b1;
				alu.wrZ  = 1'b1;
			end
			OP_AND_IMM: begin
				alu.res = alu.acc & alu.lit;     // RULE4
				alu.wrZ = 1'b1;
			end
			OP_AND_FILE: begin
				alu.res = alu.acc & alu.fileVal; // RULE5
				alu.wrZ = 1'b1;
			end
			OP_ASR: begin
				alu.res  = {alu.fileVal[7], alu.fileVal[7:1]}; // RULE9
				alu.cOut = alu.fileVal[0];
				alu.wrC  = 1'b1;
				alu.wrZ  = 1'b1;
			end
			OP_ROT_LEFT: begin
				alu.res  = {alu.fileVal[6:0], alu.cIn}; // RULE10
				alu.cOut = alu.fileVal[7];
				alu.wrC  = 1'b1;
			end
			OP_RET_LIT: alu.res = alu.lit; // RULE13
			default:    alu.res = 8'h00;
		endcase
	end

	// Zero flag from the 8-bit result only
	assign alu.zOut = (alu.res == 8'h00); // RULE14

endmodule : iex_alu

//--- core/iex_ptr.sv
/*
 * The two 16-bit indirect pointers with signed literal add and byte writes.
 * Assumes at most one add or one byte write is meaningful per cycle; add wins.
 */
`timescale 1ns/1ps
module iex_ptr
	import iex_pkg::*;
#(
	parameter int PTR_W = 16,
	parameter int LIT_W = 6
)(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	// Literal add
	input  wire logic             addEn,
	input  wire logic             addSel,
	input  wire logic [LIT_W-1:0] addLit,
	// Byte writes from the register port: index 0..3 = p0 lo, p0 hi, p1 lo, p1 hi
	input  wire logic             wrEn,
	input  wire logic [1:0]       wrIdx,
	input  wire logic [7:0]       wrData,
	// Pointer values
	output logic      [PTR_W-1:0] ptr0,
	output logic      [PTR_W-1:0] ptr1
);

	logic [PTR_W-1:0] litExt;
	logic [PTR_W-1:0] ptrQ [2];

	// Sign extension of the short literal
	assign litExt = {{(PTR_W-LIT_W){addLit[LIT_W-1]}}, addLit}; // RULE1

	// One pointer per generate slice; the add never touches the flags
	for (genvar i = 0; i < 2; i++) begin : g_ptr
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				ptrQ[i] <= PTR_RST;
			end else if (addEn && (addSel == i[0])) begin
				ptrQ[i] <= ptrQ[i] + litExt; // RULE2
			end else if (wrEn && (wrIdx[1] == i[0])) begin
				if (wrIdx[0]) begin
					ptrQ[i][PTR_W-1:8] <= wrData;
				end else begin
					ptrQ[i][7:0] <= wrData;
				end
			end
		end
	end

	assign ptr0 = ptrQ[0];
	assign ptr1 = ptrQ[1];

	// ************************************************************
	// Checks
	// ************************************************************
	ptr_add_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE2
		addEn && !addSel |=> ptr0 == PTR_W'($past(ptr0) + $past(litExt)))
		else $error("pointer 0 add did not wrap to the modular sum");

endmodule : iex_ptr

//--- tb/iex_stack_model.sv
/*
 * Return stack model standing beside the execution stage.
 * Assumes the bench preloads return addresses through pushEn/pushVal and that
 * the stage pops with a one-cycle stackPop while reading stackTop in that cycle.
 */
`timescale 1ns/1ps
module iex_stack_model #(
	parameter int PC_W  = 15,
	parameter int DEPTH = 8
)(
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst_b,
	// Bench preload
	input  wire logic            pushEn,
	input  wire logic [PC_W-1:0] pushVal,
	// Execution side
	input  wire logic            stackPop,
	output logic      [PC_W-1:0] stackTop
);

	logic [PC_W-1:0] entries [DEPTH];
	int              depth;
	logic [PC_W-1:0] lastTop;

	// An empty stack shows the inverse of the last top, so a stale word never passes
	assign stackTop = (depth > 0) ? entries[depth-1] : ~lastTop;

	// Push from the bench, pop on the stage's strobe; underflow is not modelled
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			depth   <= 0;
			lastTop <= '0;
		end else if (pushEn) begin
			entries[depth] <= pushVal;
			depth          <= depth + 1;
		end else if (stackPop && depth > 0) begin
			lastTop <= entries[depth-1];
			depth   <= depth - 1;
		end
	end

endmodule : iex_stack_model

//--- tb/tb_top.sv
/*
 * Self-checking bench for the execution stage: register port tasks, operation
 * issue, and a return stack model on the far side.
 * Assumes the register map 00-7f file, 80 acc, 81 flags, 82 interrupt control,
 * 84-87 pointers, 88/89 program counter; inputs change on the rising edge and
 * outputs are sampled on the falling edge.
 */
`timescale 1ns/1ps
module tb_top;
	import iex_pkg::*;

	// ************************************************************
	// Signals
	// ************************************************************
	logic        sys_clk    = 1'b0;
	logic        rst_b      = 1'b0;
	logic [7:0]  regAddr    = 8'h00;
	logic [7:0]  regWrData  = 8'h00;
	logic        regWr      = 1'b0;
	logic        regRd      = 1'b0;
	logic [7:0]  regRdData;
	logic        instValid  = 1'b0;
	logic [3:0]  instOp     = 4'h0;
	logic [6:0]  instFile   = 7'h00;
	logic        instDest   = 1'b0;
	logic [7:0]  instLit    = 8'h00;
	logic        instPtrSel = 1'b0;
	logic        instReady;
	logic [14:0] stackTop;
	logic        stackPop;
	logic [14:0] progCounter;
	logic        globalIntEnable;
	logic        pushEn     = 1'b0;
	logic [14:0] pushVal    = 15'h0000;
	logic        popSeen;
	int          mismatches = 0;
	int          checkCount = 0;
	int          cycleCount = 0;

	always #12.5 sys_clk = ~sys_clk;

	iex_exec i_iex_exec (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .instValid(instValid), .instOp(instOp),
		.instFile(instFile), .instDest(instDest), .instLit(instLit), .instPtrSel(instPtrSel),
		.instReady(instReady), .stackTop(stackTop), .stackPop(stackPop), .progCounter(progCounter),
		.globalIntEnable(globalIntEnable));

	iex_stack_model i_iex_stack_model (.sys_clk(sys_clk), .rst_b(rst_b), .pushEn(pushEn),
		.pushVal(pushVal), .stackPop(stackPop), .stackTop(stackTop));

	// ************************************************************
	// Compare and access tasks
	// ************************************************************
	task automatic chkVal(input string name, input logic [15:0] exp, input logic [15:0] got);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chkVal

	task automatic chkBit(input string name, input logic exp, input logic got);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", name, exp, got);
		end
	endtask : chkBit

	// A gap cycle after each strobe keeps one assignment per time step
	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		@(posedge sys_clk);
	endtask : regWrite

	// Read data appear in the cycle after the strobe and hold until the next read strobe
	task automatic regRead(input logic [7:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		chkVal($sformatf("reg %h", a), {8'h00, exp}, {8'h00, regRdData});
		@(posedge sys_clk);
	endtask : regRead

	// Hold the operation n edges; rel=0 leaves valid up for a following issue
	task automatic issue(input iex_op_t op, input logic [6:0] f, input logic d, input logic [7:0] lit,
		input logic ps, input int n, input logic rel);
		instOp     <= op;
		instFile   <= f;
		instDest   <= d;
		instLit    <= lit;
		instPtrSel <= ps;
		instValid  <= 1'b1;
		@(negedge sys_clk);
		popSeen = stackPop;
		repeat (n) @(posedge sys_clk);
		if (rel) begin
			instValid <= 1'b0;
			@(posedge sys_clk);
		end
	endtask : issue

	task automatic push(input logic [14:0] v);
		pushVal <= v;
		pushEn  <= 1'b1;
		@(posedge sys_clk);
		pushEn <= 1'b0;
		@(posedge sys_clk);
	endtask : push

	// Follows a return issued with rel=0: drops valid, then checks the stalled cycle
	task automatic retChk(input logic [14:0] expPc);
		instValid <= 1'b0;
		chkBit("stackPop", 1'b1, popSeen);
		@(negedge sys_clk);
		chkBit("instReady hold", 1'b0, instReady);
		chkVal("progCounter", {1'b0, expPc}, {1'b0, progCounter});
		@(posedge sys_clk);
		@(negedge sys_clk);
		chkBit("instReady free", 1'b1, instReady);
		@(posedge sys_clk);
	endtask : retChk

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : printVerdict

	// ************************************************************
	// Hang guard: the sequence needs under two hundred cycles
	// ************************************************************
	always @(posedge sys_clk) begin
		cycleCount++;
		if (cycleCount == 3000) begin
			mismatches++;
			printVerdict();
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		// Reset values and an unmapped place
		regRead(8'h80, 8'h00);
		regRead(8'h81, 8'h00);
		regRead(8'h82, 8'h00);
		regWrite(8'h83, 8'hff);
		regRead(8'h83, 8'h00);
		// Add immediate, back to back, digit carry then carry with zero
		regWrite(8'h80, 8'h0f);
		issue(OP_ADD_IMM, 7'h00, 1'b0, 8'h01, 1'b0, 1, 1'b0);
		issue(OP_ADD_IMM, 7'h00, 1'b0, 8'hf0, 1'b0, 1, 1'b1);
		regRead(8'h80, 8'h00);
		regRead(8'h81, 8'h05);
		// AND immediate leaves carry and digit carry alone
		regWrite(8'h80, 8'hff);
		regWrite(8'h81, 8'h03);
		issue(OP_AND_IMM, 7'h00, 1'b0, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h80, 8'h00);
		regRead(8'h81, 8'h07);
		// AND with file, both destinations, top file address
		regWrite(8'h7f, 8'h3c);
		regWrite(8'h7e, 8'h0f);
		regWrite(8'h80, 8'hf0);
		regWrite(8'h81, 8'h04);
		issue(OP_AND_FILE, 7'h7f, 1'b0, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h80, 8'h30);
		regRead(8'h81, 8'h00);
		issue(OP_AND_FILE, 7'h7e, 1'b1, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h7e, 8'h00);
		regRead(8'h80, 8'h30);
		regRead(8'h81, 8'h04);
		// Add with file back into the file
		regWrite(8'h10, 8'h88);
		regWrite(8'h80, 8'h88);
		issue(OP_ADD_FILE, 7'h10, 1'b1, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h10, 8'h10);
		regRead(8'h80, 8'h88);
		regRead(8'h81, 8'h03);
		// Add with carry: carry in set, then clear
		regWrite(8'h11, 8'h00);
		regWrite(8'h80, 8'h0f);
		issue(OP_ADD_FILE_C, 7'h11, 1'b0, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h80, 8'h10);
		regRead(8'h81, 8'h02);
		issue(OP_ADD_FILE_C, 7'h11, 1'b1, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h11, 8'h10);
		regRead(8'h81, 8'h00);
		// Arithmetic shift keeps the sign bit, digit carry untouched
		regWrite(8'h20, 8'h81);
		regWrite(8'h21, 8'h01);
		regWrite(8'h81, 8'h02);
		issue(OP_ASR, 7'h20, 1'b0, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h80, 8'hc0);
		regRead(8'h81, 8'h03);
		issue(OP_ASR, 7'h21, 1'b1, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h21, 8'h00);
		regRead(8'h81, 8'h07);
		// Rotate through carry twice in consecutive cycles, zero untouched
		regWrite(8'h30, 8'he6);
		regWrite(8'h81, 8'h04);
		issue(OP_ROT_LEFT, 7'h30, 1'b0, 8'h00, 1'b0, 1, 1'b0);
		issue(OP_ROT_LEFT, 7'h30, 1'b1, 8'h00, 1'b0, 1, 1'b1);
		regRead(8'h80, 8'hcc);
		regRead(8'h30, 8'hcd);
		regRead(8'h81, 8'h05);
		// Pointer add: wrap upward, most negative literal wraps downward
		regWrite(8'h81, 8'h07);
		regWrite(8'h84, 8'hfe);
		regWrite(8'h85, 8'hff);
		regWrite(8'h86, 8'h10);
		regWrite(8'h87, 8'h00);
		issue(OP_PTR_ADD, 7'h00, 1'b0, 8'h05, 1'b0, 1, 1'b0);
		issue(OP_PTR_ADD, 7'h00, 1'b0, 8'he0, 1'b1, 1, 1'b1);
		regRead(8'h84, 8'h03);
		regRead(8'h85, 8'h00);
		regRead(8'h86, 8'hf0);
		regRead(8'h87, 8'hff);
		regRead(8'h81, 8'h07);
		// Returns pop the stack in order
		push(15'h1234);
		push(15'h2222);
		push(15'h7abc);
		issue(OP_RET_INT, 7'h00, 1'b0, 8'h00, 1'b0, 1, 1'b0);
		retChk(15'h7abc);
		chkBit("globalIntEnable", 1'b1, globalIntEnable);
		regRead(8'h82, 8'h80);
		regRead(8'h88, 8'hbc);
		regRead(8'h89, 8'h7a);
		regWrite(8'h82, 8'h00);
		regRead(8'h82, 8'h00);
		regWrite(8'h81, 8'h05);
		issue(OP_RET, 7'h00, 1'b0, 8'h00, 1'b0, 1, 1'b0);
		retChk(15'h2222);
		regRead(8'h81, 8'h05);
		// Literal return with an add held across the stalled cycle: taken once
		issue(OP_RET_LIT, 7'h00, 1'b0, 8'h5a, 1'b0, 1, 1'b0);
		chkBit("stackPop", 1'b1, popSeen);
		issue(OP_ADD_IMM, 7'h00, 1'b0, 8'h01, 1'b0, 2, 1'b1);
		chkVal("progCounter", 16'h1234, {1'b0, progCounter});
		regRead(8'h80, 8'h5b);
		printVerdict();
	end

endmodule : tb_top
